// [common/ctl_if.sv]
// Purpose: carrier between line filter, pump sequencer and core
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
`include "led_prog_consts.svh"
interface ctl_if;
  logic lvl;
  logic fall;
  logic [`TCNT_W-1:0] phase_cnt;
  logic fail;
  logic unity_ok;
  logic lockout;
  logic restart;
  logic hold;
  led_prog_pkg::pump_mode_t mode;
  modport filt (output lvl, fall, phase_cnt);
  modport seq (input fail, unity_ok, lockout, restart, hold, output mode);
  modport core (input lvl, fall, phase_cnt, mode,
                output fail, unity_ok, lockout, restart, hold);
endinterface

// [common/led_prog_consts.svh]
// Purpose: timing counts, offsets and reset values of the LED programmer
// Assumes: 125 MHz system clock
// Notes: a least time rounds up, a longest time rounds down
`ifndef LED_PROG_CONSTS_SVH
`define LED_PROG_CONSTS_SVH

`define CLK_MHZ 125
`define TCNT_W 18

// shortest pulse phase that is counted
`define T_GLITCH_NS 200
`define GLITCH_CYC ((`T_GLITCH_NS * `CLK_MHZ + 999) / 1000)
// longest pulse phase; a longer high ends a burst
`define PHASE_MAX_US 100
`define HI_MAX_CYC (`PHASE_MAX_US * `CLK_MHZ)
// longest wait from address burst end to first data fall
`define T_DATA_WIN_US 1000
`define DATA_WIN_CYC (`T_DATA_WIN_US * `CLK_MHZ)
// low time that requests shutdown
`define T_OFF_US 1500
`define OFF_CYC (`T_OFF_US * `CLK_MHZ)
// power-down delay after shutdown is requested
`define T_PDN_US 1000
`define PDN_CYC (`T_PDN_US * `CLK_MHZ)
// gain step filter delay
`define T_FILT_US 400
`define FILT_CYC (`T_FILT_US * `CLK_MHZ)

// register bus map, byte addresses
`define ADR_LINK_CTRL 8'h00
`define ADR_PROG_REGS 8'h04
`define ADR_LINK_STAT 8'h08
`define CTRL_LINK_EN 0
`define CTRL_RESTART 1
`define CTRL_RST 1'h1
`define ADDR_LAST 5'h06
`define CNT_SAT 5'h1F

`endif

// [common/led_prog_pkg.sv]
// Purpose: shared types of the LED programmer
// Assumes: nothing
// Notes: one-hot state codes
package led_prog_pkg;
  typedef enum logic [3:0] {
    PM_1X = 4'h1,
    PM_133 = 4'h2,
    PM_15 = 4'h4,
    PM_2X = 4'h8
  } pump_mode_t;
  typedef enum logic [4:0] {
    LS_ADDR = 5'h01,
    LS_GAP = 5'h02,
    LS_DATA = 5'h04,
    LS_PDN = 5'h08,
    LS_OFF = 5'h10
  } link_state_t;
endpackage

// [design/led_prog_top.sv]
// Purpose: one-wire pulse-count programmer and control of a six-LED driver
// Assumes: 125 MHz clock, line and analog flags synchronous to it
// Notes: rules of the block follow
`timescale 1ns/1ps
`include "led_prog_consts.svh"
module led_prog_top #(
  parameter int unsigned HI_MAX_CYC = `HI_MAX_CYC,
  parameter int unsigned DATA_WIN_CYC = `DATA_WIN_CYC,
  parameter int unsigned OFF_CYC = `OFF_CYC,
  parameter int unsigned PDN_CYC = `PDN_CYC,
  parameter int unsigned FILT_CYC = `FILT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // one-wire enable and control line
  input wire logic en_set_in,
  // analog status
  input wire logic reg_fail_in,
  input wire logic unity_ok_in,
  input wire logic low_supply_cutoff_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // driver controls
  output logic current_range_select_out,
  output logic bank_a_on_out,
  output logic bank_b_on_out,
  output logic bank_c_on_out,
  output logic [3:0] global_code_out,
  output logic [3:0] bank_a_code_out,
  output logic [3:0] bank_b_code_out,
  output logic [3:0] bank_c_code_out,
  output logic [5:0] led_sink_outputs_oe_out,
  output logic unity_return_block_out,
  output led_prog_pkg::pump_mode_t pump_mode_out,
  output logic shutdown_out
);
  import led_prog_pkg::*;
  localparam logic [`TCNT_W-1:0] HI_MAX = `TCNT_W'(HI_MAX_CYC);
  localparam logic [`TCNT_W-1:0] WIN_MAX = `TCNT_W'(DATA_WIN_CYC);
  localparam logic [`TCNT_W-1:0] OFF_MAX = `TCNT_W'(OFF_CYC);
  localparam logic [`TCNT_W-1:0] PDN_MAX = `TCNT_W'(PDN_CYC - 1);

  ctl_if ctl();

  line_filter u_filt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .line_in(en_set_in),
    .ctl(ctl.filt)
  );

  pump_sequencer #(.FILT_CYC(FILT_CYC)) u_pump (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ctl(ctl.seq)
  );

  function automatic logic addr_ok(input logic [4:0] n);
    return n != 5'h00 && n <= `ADDR_LAST;
  endfunction

  link_state_t st_q;
  logic [4:0] pcnt_q;
  logic [2:0] sel_q;
  logic [`TCNT_W-1:0] pdn_q;
  logic [3:0] cur_q [5];
  logic lock_q;
  logic link_en_q;
  logic restart_q;
  logic burst_end;
  logic addr_hit;
  logic data_hit;
  logic sdn_hit;
  logic drive;
  logic low_sup;
  logic wb_req;
  logic wb_wr;

  always_comb begin
    low_sup = low_supply_cutoff_in;
    // a high longer than any pulse phase closes a burst
    burst_end = ctl.lvl && ctl.phase_cnt == HI_MAX;
    addr_hit = st_q == LS_ADDR && burst_end && link_en_q &&
               addr_ok(pcnt_q);
    data_hit = st_q == LS_DATA && burst_end;
    sdn_hit = !ctl.lvl && ctl.phase_cnt >= OFF_MAX &&
              st_q inside {LS_ADDR, LS_GAP, LS_DATA};
    drive = st_q != LS_OFF && !low_sup;
    wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wb_wr = wb_req && wb_we_in && wb_adr_in == `ADR_LINK_CTRL &&
            wb_sel_in[0];
  end

  always_comb begin
    ctl.fail = reg_fail_in;
    ctl.unity_ok = unity_ok_in;
    ctl.lockout = lock_q;
    ctl.restart = (addr_hit && pcnt_q == `ADDR_LAST) || restart_q;
    ctl.hold = !drive;
  end

  // link sequencing; reset lands in address wait
  always_ff @(posedge clk_in) begin
    if (rst_in || low_sup) begin
      st_q <= LS_ADDR;
    end else if (sdn_hit) begin
      st_q <= LS_PDN;
    end else begin
      unique case (st_q)
        LS_ADDR: begin
          if (addr_hit) begin
            st_q <= LS_GAP;
          end
        end
        LS_GAP: begin
          if (ctl.fall) begin
            st_q <= LS_DATA;
          end else if (ctl.phase_cnt >= WIN_MAX) begin
            st_q <= LS_ADDR;
          end
        end
        LS_DATA: begin
          if (data_hit) begin
            st_q <= LS_ADDR;
          end
        end
        LS_PDN: begin
          if (ctl.lvl) begin
            st_q <= LS_ADDR;
          end else if (pdn_q == PDN_MAX) begin
            st_q <= LS_OFF;
          end
        end
        LS_OFF: begin
          if (ctl.lvl) begin
            st_q <= LS_ADDR;
          end
        end
        default: st_q <= LS_ADDR;
      endcase
    end
  end

  // falling edge counter for address and data bursts
  always_ff @(posedge clk_in) begin
    if (rst_in || burst_end || !link_en_q ||
        !(st_q inside {LS_ADDR, LS_GAP, LS_DATA})) begin
      pcnt_q <= 5'h00;
    end else if (ctl.fall && pcnt_q != `CNT_SAT) begin
      pcnt_q <= pcnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sel_q <= 3'h0;
    end else if (addr_hit) begin
      sel_q <= pcnt_q[2:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || st_q != LS_PDN) begin
      pdn_q <= '0;
    end else begin
      pdn_q <= pdn_q + `TCNT_W'(1);
    end
  end

  // programmed registers; index 0..4 hold registers one to five
  always_ff @(posedge clk_in) begin
    if (rst_in || low_sup || st_q == LS_OFF) begin
      for (int i = 0; i < 5; i++) begin
        cur_q[i] <= 4'h0;
      end
      lock_q <= 1'b0;
    end else if (addr_hit) begin
      if (pcnt_q == `ADDR_LAST) begin
        lock_q <= 1'b0;
      end else begin
        cur_q[3'(pcnt_q[2:0] - 3'h1)] <= 4'h0;
      end
    end else if (data_hit) begin
      if (sel_q == 3'h6) begin
        lock_q <= pcnt_q == 5'h01;
      end else begin
        cur_q[3'(sel_q - 3'h1)] <= 4'(5'h10 - pcnt_q);
      end
    end
  end

  // outputs follow the registers one cycle late, all from flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      current_range_select_out <= 1'b0;
      bank_a_on_out <= 1'b0;
      bank_b_on_out <= 1'b0;
      bank_c_on_out <= 1'b0;
      global_code_out <= 4'h0;
      bank_a_code_out <= 4'h0;
      bank_b_code_out <= 4'h0;
      bank_c_code_out <= 4'h0;
      led_sink_outputs_oe_out <= 6'h00;
      unity_return_block_out <= 1'b0;
      shutdown_out <= 1'b0;
    end else begin
      current_range_select_out <= cur_q[0][3];
      bank_a_on_out <= cur_q[0][2] && drive;
      bank_b_on_out <= cur_q[0][1] && drive;
      bank_c_on_out <= cur_q[0][0] && drive;
      global_code_out <= cur_q[1];
      bank_a_code_out <= cur_q[2];
      bank_b_code_out <= cur_q[3];
      bank_c_code_out <= cur_q[4];
      led_sink_outputs_oe_out <= {{2{cur_q[0][0]}}, {2{cur_q[0][1]}},
        {2{cur_q[0][2]}}} & {6{drive}};
      unity_return_block_out <= lock_q;
      shutdown_out <= st_q == LS_OFF;
    end
  end

  assign pump_mode_out = ctl.mode;

  // bus slave: answers every access one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      link_en_q <= `CTRL_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wb_wr && wb_dat_in[`CTRL_RESTART];
      if (wb_wr) begin
        link_en_q <= wb_dat_in[`CTRL_LINK_EN];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_req) begin
      unique case (wb_adr_in)
        `ADR_LINK_CTRL: wb_dat_out <= {31'h0000_0000, link_en_q};
        `ADR_PROG_REGS: wb_dat_out <= {11'h000, lock_q, cur_q[4],
          cur_q[3], cur_q[2], cur_q[1], cur_q[0]};
        `ADR_LINK_STAT: wb_dat_out <= {22'h00_0000, ctl.lvl, st_q,
          ctl.mode};
        default: wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  a_addr_clear: assert property (
    @(posedge clk_in) disable iff (rst_in)
    addr_hit && pcnt_q == 5'h02 && !low_sup |=> cur_q[1] == 4'h0)
    else $error("addressed register not cleared");
  a_data_code: assert property (
    @(posedge clk_in) disable iff (rst_in)
    data_hit && sel_q == 3'h3 && !low_sup
    |=> cur_q[2] == 4'(5'h10 - $past(pcnt_q)))
    else $error("wrong current code stored");
  a_lock_bit: assert property (
    @(posedge clk_in) disable iff (rst_in)
    data_hit && sel_q == 3'h6 && !low_sup
    |=> lock_q == ($past(pcnt_q) == 5'h01))
    else $error("lockout bit wrong");
  a_gap_timeout: assert property (
    @(posedge clk_in) disable iff (rst_in)
    st_q == LS_GAP && !ctl.fall && ctl.phase_cnt >= WIN_MAX
    |=> st_q == LS_ADDR)
    else $error("data window did not time out");
  a_sdn_entry: assert property (
    @(posedge clk_in) disable iff (rst_in)
    st_q == LS_ADDR && !low_sup && !ctl.lvl && ctl.phase_cnt >= OFF_MAX
    |=> st_q == LS_PDN ##1 (st_q == LS_PDN || ctl.lvl))
    else $error("long low did not start power-down");
  a_off_sinks: assert property (
    @(posedge clk_in) disable iff (rst_in)
    st_q == LS_OFF |=> led_sink_outputs_oe_out == 6'h00 && shutdown_out)
    else $error("sinks driven in shutdown");
  a_supply_clear: assert property (
    @(posedge clk_in) disable iff (rst_in)
    low_sup |=> cur_q[0] == 4'h0 && !lock_q ##1 !bank_a_on_out)
    else $error("low supply did not clear registers");
endmodule // led_prog_top

// [design/line_filter.sv]
// Purpose: deglitch the control line and time each of its phases
// Assumes: line input synchronous to clk_in
// Notes: accepted edges lag the pin by the glitch time
`timescale 1ns/1ps
`include "led_prog_consts.svh"
module line_filter #(
  parameter int unsigned GL_CYC = `GLITCH_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // line and results
  input wire logic line_in,
  ctl_if.filt ctl
);
  logic lvl_q;
  logic fall_q;
  logic [4:0] st_q;
  logic [`TCNT_W-1:0] cnt_q;
  logic flip;

  assign flip = (line_in != lvl_q) && (st_q == 5'(GL_CYC - 1));

  // a level must persist the glitch time before it counts
  always_ff @(posedge clk_in) begin
    if (rst_in || line_in == lvl_q || flip) begin
      st_q <= 5'h00;
    end else begin
      st_q <= st_q + 5'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lvl_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      lvl_q <= flip ? line_in : lvl_q;
      fall_q <= flip && lvl_q;
    end
  end

  // phase timebase cleared on each accepted edge, saturating so long lows still read large
  always_ff @(posedge clk_in) begin
    if (rst_in || flip) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + `TCNT_W'(1);
    end
  end

  assign ctl.lvl = lvl_q;
  assign ctl.fall = fall_q;
  assign ctl.phase_cnt = cnt_q;

  a_glitch_drop: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $fell(lvl_q) |-> !$past(line_in, 1) && !$past(line_in, 25))
    else $error("line fell after a short low");
endmodule // line_filter

// [design/pump_sequencer.sv]
// Purpose: charge pump gain selection
// Assumes: fail and unity_ok come from the regulation comparators
// Notes: steps up one gain per filter delay, steps down only to 1x
`timescale 1ns/1ps
`include "led_prog_consts.svh"
module pump_sequencer #(
  parameter int unsigned FILT_CYC = `FILT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control and mode
  ctl_if.seq ctl
);
  import led_prog_pkg::*;
  localparam logic [`TCNT_W-1:0] FILT_MAX = `TCNT_W'(FILT_CYC - 1);
  pump_mode_t mode_q;
  logic [`TCNT_W-1:0] fcnt_q;
  logic step;

  assign step = ctl.fail && fcnt_q == FILT_MAX;

  // failure must last the whole filter delay before a step
  always_ff @(posedge clk_in) begin
    if (rst_in || !ctl.fail || ctl.restart || ctl.hold ||
        mode_q == PM_2X || step) begin
      fcnt_q <= '0;
    end else begin
      fcnt_q <= fcnt_q + `TCNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || ctl.restart || ctl.hold) begin
      mode_q <= PM_1X;
    end else if (step) begin
      unique case (mode_q)
        PM_1X: mode_q <= PM_133;
        PM_133: mode_q <= PM_15;
        PM_15: mode_q <= PM_2X;
        PM_2X: mode_q <= PM_2X;
        default: mode_q <= PM_1X;
      endcase
    end else if (ctl.unity_ok && !ctl.lockout) begin
      mode_q <= PM_1X;
    end
  end

  assign ctl.mode = mode_q;

  a_pump_step: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mode_q == PM_1X && !ctl.restart && !ctl.hold && fcnt_q == FILT_MAX
    && ctl.fail |=> mode_q == PM_133)
    else $error("no step to 1.33x after filter delay");
  a_pump_return: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mode_q != PM_1X && ctl.unity_ok && !ctl.lockout && !ctl.fail
    |=> mode_q == PM_1X)
    else $error("no return to 1x");
  a_no_mid_down: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mode_q == PM_2X |=> mode_q inside {PM_2X, PM_1X})
    else $error("stepped down to intermediate gain");
endmodule // pump_sequencer

// [verif/host_line_model.sv]
// Purpose: host that drives the one-wire enable and control line
// Assumes: clk_in is the bench clock, 8 ns period
// Notes: gaps follow the shortened timing parameters of the bench
`timescale 1ns/1ps
module host_line_model (
  // clock
  input wire logic clk_in,
  // control line
  output logic line_out
);
  // a push-pull pin: the host always drives a level, high when idle
  initial line_out = 1'b1;

  task automatic hold(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge clk_in);
  endtask

  // 50 cycles is 400 ns, well inside the legal phase span
  task automatic burst(input int n);
    repeat (n) begin
      hold(1'b0, 50);
      hold(1'b1, 50);
    end
  endtask

  // too short to count, so the device must drop it
  task automatic glitch();
    hold(1'b0, 10);
    hold(1'b1, 50);
  endtask

  task automatic prog_reg(input int a, input int n);
    burst(a);
    hold(1'b1, 1000);
    burst(n);
    hold(1'b1, 3000);
  endtask
endmodule // host_line_model

// [verif/tb.sv]
// Purpose: self-checking bench of the LED programmer
// Assumes: shortened timing parameters keep the run brief
// Notes: the host model drives the line, the bench the bus and flags
`timescale 1ns/1ps
module tb;
  import led_prog_pkg::*;
  localparam int OFF = 3000;
  localparam int PDN = 500;
  localparam int FILT = 100;
  logic clk_in, rst_in, line, fail, uok, low_sup, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rq, word;
  logic ack, rng, a_on, b_on, c_on, lock, sd;
  logic [3:0] g_code, a_code, b_code, c_code;
  logic [5:0] oe;
  pump_mode_t mode;
  int errors = 0;
  int compares = 0;
  int cnt[5] = '{1, 1, 5, 16, 15};

  host_line_model host (.clk_in(clk_in), .line_out(line));

  led_prog_top #(
    .HI_MAX_CYC(200), .DATA_WIN_CYC(2000), .OFF_CYC(OFF),
    .PDN_CYC(PDN), .FILT_CYC(FILT)
  ) dut (
    .clk_in(clk_in), .rst_in(rst_in), .en_set_in(line),
    .reg_fail_in(fail), .unity_ok_in(uok), .low_supply_cutoff_in(low_sup),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
    .wb_ack_out(ack), .current_range_select_out(rng),
    .bank_a_on_out(a_on), .bank_b_on_out(b_on), .bank_c_on_out(c_on),
    .global_code_out(g_code), .bank_a_code_out(a_code),
    .bank_b_code_out(b_code), .bank_c_code_out(c_code),
    .led_sink_outputs_oe_out(oe), .unity_return_block_out(lock),
    .pump_mode_out(mode), .shutdown_out(sd)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; ack and read data are taken at the same edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= w ? 4'h1 : 4'hF;
    dat_w <= d;
    // no cycle limit here: only the watchdog ends a hung access
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    rq = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rq);
  endtask

  task automatic done(input string s);
    $display("test %s ended after %0d compares", s, compares);
  endtask

  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the tests need about 70000 cycles
  initial begin
    cyc_wait(95000);
    errors++;
    conclude();
  end

  initial begin
    rst_in = 1'b1;
    fail = 1'b0;
    uok = 1'b0;
    low_sup = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h1;
    dat_w = 32'h0000_0000;
    cyc_wait(2);
    rst_in <= 1'b0;
    host.hold(1'b1, 1300);
    chk("mode", PM_1X, mode);
    chk("shutdown", 1'b0, sd);
    chk_rd("ctrl", 8'h00, 32'h0000_0001);
    chk_rd("unmapped", 8'h0C, 32'h0000_0000);
    chk_rd("regs", 8'h04, 32'h0000_0000);
    chk_rd("status", 8'h08, 32'h0000_0211);
    done("reset");
    // with the link disabled a whole frame must be ignored
    wb(1'b1, 8'h00, 32'h0000_0000);
    host.prog_reg(2, 3);
    chk("global", 4'h0, g_code);
    chk_rd("ctrl", 8'h00, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0001);
    done("link disable");
    word = 32'h0000_0000;
    foreach (cnt[i]) begin
      host.prog_reg(i + 1, cnt[i]);
      word[4*i +: 4] = 4'((16 - cnt[i]) % 16);
    end
    chk_rd("regs", 8'h04, word);
    chk("reg1", 4'hF, {rng, a_on, b_on, c_on});
    chk("codes", 16'h10BF, {c_code, b_code, a_code, g_code});
    done("program");
    host.burst(3);
    host.hold(1'b1, 4000);
    chk("bank_a", 4'h0, a_code);
    host.prog_reg(2, 4);
    chk("global", 4'hC, g_code);
    chk("bank_a", 4'h0, a_code);
    host.burst(2);
    host.hold(1'b1, 1000);
    host.burst(1);
    host.glitch();
    host.burst(1);
    host.hold(1'b1, 3000);
    chk("global", 4'hE, g_code);
    done("timeout and glitch");
    fail <= 1'b1;
    cyc_wait(FILT - 10);
    chk("mode", PM_1X, mode);
    cyc_wait(40);
    chk("mode", PM_133, mode);
    cyc_wait(FILT + 10);
    chk("mode", PM_15, mode);
    cyc_wait(FILT + 10);
    chk("mode", PM_2X, mode);
    fail <= 1'b0;
    cyc_wait(2 * FILT);
    chk("mode", PM_2X, mode);
    uok <= 1'b1;
    cyc_wait(4);
    chk("mode", PM_1X, mode);
    uok <= 1'b0;
    host.prog_reg(6, 1);
    chk("lockout", 1'b1, lock);
    fail <= 1'b1;
    cyc_wait(FILT + 30);
    fail <= 1'b0;
    uok <= 1'b1;
    cyc_wait(2 * FILT);
    chk("mode", PM_133, mode);
    wb(1'b1, 8'h00, 32'h0000_0003);
    cyc_wait(4);
    chk("mode", PM_1X, mode);
    uok <= 1'b0;
    fail <= 1'b1;
    cyc_wait(FILT + 30);
    fail <= 1'b0;
    host.burst(6);
    host.hold(1'b1, 400);
    chk("mode", PM_1X, mode);
    chk("lockout", 1'b0, lock);
    host.hold(1'b1, 3600);
    done("pump");
    low_sup <= 1'b1;
    cyc_wait(5);
    chk_rd("regs", 8'h04, 32'h0000_0000);
    chk("oe", 6'h00, oe);
    chk("reg1", 4'h0, {rng, a_on, b_on, c_on});
    low_sup <= 1'b0;
    done("low supply");
    host.prog_reg(2, 1);
    host.hold(1'b0, OFF + PDN - 100);
    chk("shutdown", 1'b0, sd);
    host.hold(1'b0, 200);
    chk("shutdown", 1'b1, sd);
    chk("oe", 6'h00, oe);
    chk("global", 4'h0, g_code);
    host.hold(1'b1, 1300);
    chk("shutdown", 1'b0, sd);
    chk_rd("regs", 8'h04, 32'h0000_0000);
    host.prog_reg(3, 2);
    chk("bank_a", 4'hE, a_code);
    done("shutdown");
    fail <= 1'b1;
    cyc_wait(FILT + 10);
    chk("mode", PM_133, mode);
    rst_in <= 1'b1;
    cyc_wait(2);
    rst_in <= 1'b0;
    chk("mode", PM_1X, mode);
    chk("bank_a", 4'h0, a_code);
    fail <= 1'b0;
    chk_rd("regs", 8'h04, 32'h0000_0000);
    chk_rd("ctrl", 8'h00, 32'h0000_0001);
    done("mid reset");
    conclude();
  end
endmodule // tb
